// File: rtl/timer8_cfg.svh
`ifndef TIMER8_CFG_SVH
`define TIMER8_CFG_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define IDX_COUNTER_CH0      16'hFF16
`define IDX_COMPARE_CH0      16'hFF17
`define IDX_CLKSEL_CH0       16'hFF6A
`define IDX_MODE_CH0         16'hFF6B
`define IDX_IRQ_STATUS_CH0   16'hFF70
`define IDX_IRQ_MASK_CH0     16'hFF71
`define IDX_COUNTER_CH1      16'hFF1F
`define IDX_COMPARE_CH1      16'hFF41
`define IDX_CLKSEL_CH1       16'hFF8C
`define IDX_MODE_CH1         16'hFF43
`define IDX_IRQ_STATUS_CH1   16'hFF72
`define IDX_IRQ_MASK_CH1     16'hFF73

// ----------------------------------------------------------------------------
// Mode control and interrupt mask field positions
// ----------------------------------------------------------------------------
`define BIT_COUNT_ENABLE     7
`define BIT_PWM_MODE         6
`define BIT_LEVEL_SET        3
`define BIT_LEVEL_RESET      2
`define BIT_INVERT           1
`define BIT_OUTPUT_ENABLE    0
`define BIT_MATCH_IRQ        0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_BYTE             8'h00
`define RST_CLKSEL           3'h0

// ----------------------------------------------------------------------------
// Prescaler exponents per channel
// ----------------------------------------------------------------------------
`define PRESCALE_WIDTH       13
`define EXP_DIV2             1
`define EXP_DIV64            6
`define EXP_DIV256           8
`define EXP_CODE4_CH0        2
`define EXP_CODE4_CH1        4
`define EXP_CODE7_CH0        13
`define EXP_CODE7_CH1        12

`endif

// File: rtl/timer8_pkg.sv
`default_nettype none
package timer8_pkg;
    typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_t;
    typedef logic [7:0] byte_t;
    typedef logic [2:0] clk_sel_t;
endpackage
`default_nettype wire

// File: rtl/count_clock_select.sv
`timescale 1ns/10ps
`default_nettype none
`include "timer8_cfg.svh"
module count_clock_select
    import timer8_pkg::*;
#(
    parameter int EXP_CODE4 = `EXP_CODE4_CH0,
    parameter int EXP_CODE7 = `EXP_CODE7_CH0
) (
    // Clock and reset.
    input  wire logic     clk,
    input  wire logic     sys_rst,
    // Selection and pin.
    input  wire clk_sel_t clock_select,
    input  wire logic     event_input_pin,
    // One-cycle count enable pulse.
    output logic          count_tick
);
    // ------------------------------------------------------------------------
    // Free-running prescaler
    // ------------------------------------------------------------------------
    logic [`PRESCALE_WIDTH-1:0] prescale;
    logic                       event_prev;

    // A divide by two to the e fires when the low e bits are all ones.
    function automatic logic low_ones(input logic [`PRESCALE_WIDTH-1:0] p, input int e);
        logic [`PRESCALE_WIDTH-1:0] m;
        m = `PRESCALE_WIDTH'((32'd1 << e) - 32'd1);
        return (p & m) == m;
    endfunction

    // The prescaler never stops, so a divided rate may start up to one period late.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prescale <= '0;
        end else begin
            prescale <= prescale + `PRESCALE_WIDTH'(1);
        end
    end

    // Pin is synchronous already; one delayed copy gives the edges.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            event_prev <= 1'b0;
        end else begin
            event_prev <= event_input_pin;
        end
    end

    // Source multiplexer; the two channels differ only in codes 100 and 111.
    always_comb begin
        case (clock_select)
            3'h0:    count_tick = event_prev & ~event_input_pin;
            3'h1:    count_tick = ~event_prev & event_input_pin;
            3'h2:    count_tick = 1'b1;
            3'h3:    count_tick = low_ones(prescale, `EXP_DIV2);
            3'h4:    count_tick = low_ones(prescale, EXP_CODE4);
            3'h5:    count_tick = low_ones(prescale, `EXP_DIV64);
            3'h6:    count_tick = low_ones(prescale, `EXP_DIV256);
            3'h7:    count_tick = low_ones(prescale, EXP_CODE7);
            default: count_tick = 1'b0;
        endcase
    end
endmodule // count_clock_select
`default_nettype wire

// File: rtl/eight_bit_timer_event_counter.sv
// Summary of operation
// - Read-only 8-bit counter increments per count tick.
// - Counter clears on reset, stop, non-PWM match.
// - Non-PWM compare equality raises match interrupt.
// - PWM match makes output inactive, no interrupt.
// - Compare register full-range read/write, resets zero.
// - Channel 0 clock select code table.
// - Clock select byte-writable, resets zero.
// - Count enable one runs, zero stops clears.
// - Mode bit: zero clear-start, one PWM.
// - Level pair 01 clears, 10 sets flop, on non-PWM writes.
// - Output enable zero holds low; polarity bit.
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
`include "timer8_cfg.svh"
module eight_bit_timer_event_counter
    import timer8_pkg::*;
#(
    parameter int CHANNEL   = 0,
    parameter int EXP_CODE7 = (CHANNEL == 0) ? `EXP_CODE7_CH0 : `EXP_CODE7_CH1
) (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Avalon-MM slave, word addressed.
    input  wire logic [15:0] address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [3:0]  byteenable,
    input  wire logic [31:0] writedata,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    // Timer pins and interrupt.
    input  wire logic        event_input_pin,
    output logic             timer_output_pin,
    output logic             match_irq
);
    // ------------------------------------------------------------------------
    // Channel address map
    // ------------------------------------------------------------------------
    localparam logic [15:0] IDX_COUNTER = (CHANNEL == 0) ? `IDX_COUNTER_CH0 : `IDX_COUNTER_CH1;
    localparam logic [15:0] IDX_COMPARE = (CHANNEL == 0) ? `IDX_COMPARE_CH0 : `IDX_COMPARE_CH1;
    localparam logic [15:0] IDX_CLKSEL  = (CHANNEL == 0) ? `IDX_CLKSEL_CH0  : `IDX_CLKSEL_CH1;
    localparam logic [15:0] IDX_MODE    = (CHANNEL == 0) ? `IDX_MODE_CH0    : `IDX_MODE_CH1;
    localparam logic [15:0] IDX_STATUS  = (CHANNEL == 0) ? `IDX_IRQ_STATUS_CH0 : `IDX_IRQ_STATUS_CH1;
    localparam logic [15:0] IDX_MASK    = (CHANNEL == 0) ? `IDX_IRQ_MASK_CH0   : `IDX_IRQ_MASK_CH1;
    localparam int          EXP_CODE4   = (CHANNEL == 0) ? `EXP_CODE4_CH0 : `EXP_CODE4_CH1;

    bus_state_t bus_state;
    byte_t      up_counter;
    byte_t      compare_value;
    clk_sel_t   clock_select_reg;
    logic       count_enable;
    logic       pwm_mode_select;
    logic       invert_or_polarity;
    logic       output_enable;
    logic       out_ff;
    logic       irq_status;
    logic       irq_mask;
    logic       count_tick;
    logic       wr_lane0;
    logic       wr_compare;
    logic       wr_clksel;
    logic       wr_mode;
    logic       match_event;
    logic       at_match;
    logic       rd_status;
    logic       pwm_active;

    // ------------------------------------------------------------------------
    // Count clock source
    // ------------------------------------------------------------------------
    count_clock_select #(
        .EXP_CODE4       (EXP_CODE4),
        .EXP_CODE7       (EXP_CODE7)
    ) u_clk_sel (
        .clk             (clk),
        .sys_rst         (sys_rst),
        .clock_select    (clock_select_reg),
        .event_input_pin (event_input_pin),
        .count_tick      (count_tick)
    );

    // ------------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------------
    // Every access takes one wait cycle; the answer edge is where it takes effect.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bus_state <= BUS_IDLE;
        end else begin
            case (bus_state)
                BUS_IDLE: bus_state <= (read || write) ? BUS_ACK : BUS_IDLE;
                BUS_ACK:  bus_state <= BUS_IDLE;
                default:  bus_state <= BUS_IDLE;
            endcase
        end
    end

    assign waitrequest = (bus_state != BUS_ACK);

    // Write strobes; only byte lane 0 carries register data.
    assign wr_lane0   = (bus_state == BUS_ACK) && write && byteenable[0];
    assign wr_compare = wr_lane0 && (address == IDX_COMPARE);
    assign wr_clksel  = wr_lane0 && (address == IDX_CLKSEL);
    assign wr_mode    = wr_lane0 && (address == IDX_MODE);
    assign rd_status  = (bus_state == BUS_ACK) && read && (address == IDX_STATUS);

    // Read data are latched while waiting; unmapped indices read zero.
    // The level pair is write-only and reads back as zero.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            readdata <= 32'h00000000;
        end else if (bus_state == BUS_IDLE && read) begin
            case (address)
                IDX_COUNTER: readdata <= {24'h000000, up_counter};
                IDX_COMPARE: readdata <= {24'h000000, compare_value};
                IDX_CLKSEL:  readdata <= {29'h00000000, clock_select_reg};
                IDX_MODE:    readdata <= {24'h000000, count_enable, pwm_mode_select, 4'h0,
                                          invert_or_polarity, output_enable};
                IDX_STATUS:  readdata <= {31'h00000000, irq_status};
                IDX_MASK:    readdata <= {31'h00000000, irq_mask};
                default:     readdata <= 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------------
    // Compare accepts any byte; no write guard, so software owns safe timing.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            compare_value <= `RST_BYTE;
        end else if (wr_compare) begin
            compare_value <= writedata[7:0];
        end
    end

    // Only the three select bits are stored, so the upper bits read zero.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            clock_select_reg <= `RST_CLKSEL;
        end else if (wr_clksel) begin
            clock_select_reg <= writedata[2:0];
        end
    end

    // Mode control fields.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count_enable       <= 1'b0;
            pwm_mode_select    <= 1'b0;
            invert_or_polarity <= 1'b0;
            output_enable      <= 1'b0;
        end else if (wr_mode) begin
            count_enable       <= writedata[`BIT_COUNT_ENABLE];
            pwm_mode_select    <= writedata[`BIT_PWM_MODE];
            invert_or_polarity <= writedata[`BIT_INVERT];
            output_enable      <= writedata[`BIT_OUTPUT_ENABLE];
        end
    end

    // ------------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------------
    assign at_match    = (up_counter == compare_value);
    assign match_event = count_enable && count_tick && !pwm_mode_select && at_match;

    // Stopping clears immediately; a match clears at the next count tick.
    always_ff @(posedge clk) begin
        if (sys_rst || !count_enable) begin
            up_counter <= `RST_BYTE;
        end else if (count_tick) begin
            if (match_event) begin
                up_counter <= `RST_BYTE;
            end else begin
                up_counter <= up_counter + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Output flip-flop and pin
    // ------------------------------------------------------------------------
    // Level pair 11 is prohibited and is ignored here; a level write beats a toggle.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            out_ff <= 1'b0;
        end else if (wr_mode && !writedata[`BIT_PWM_MODE] &&
                     (writedata[`BIT_LEVEL_SET] ^ writedata[`BIT_LEVEL_RESET])) begin
            out_ff <= writedata[`BIT_LEVEL_SET];
        end else if (match_event && invert_or_polarity) begin
            out_ff <= ~out_ff;
        end
    end

    // PWM is active from the wrap to zero until the count reaches compare.
    assign pwm_active = count_enable && (up_counter < compare_value);

    // The pin follows the mode bits even while the counter is stopped.
    always_ff @(posedge clk) begin
        if (sys_rst || !output_enable) begin
            timer_output_pin <= 1'b0;
        end else if (pwm_mode_select) begin
            timer_output_pin <= pwm_active ^ invert_or_polarity;
        end else begin
            timer_output_pin <= out_ff;
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt
    // ------------------------------------------------------------------------
    // A read clears only a bit that it reported, so a match between latch and answer is not lost.
    // A match in the same cycle as the clearing read is kept as well: set wins.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_status <= 1'b0;
        end else begin
            irq_status <= (irq_status && !(rd_status && readdata[0])) || match_event;
        end
    end

    // Mask register.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_mask <= 1'b0;
        end else if (wr_lane0 && address == IDX_MASK) begin
            irq_mask <= writedata[`BIT_MATCH_IRQ];
        end
    end

    assign match_irq = irq_status && irq_mask;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    property p_count_step;
        @(posedge clk) disable iff (sys_rst)
        (count_enable && count_tick && !at_match) ##1 count_enable |-> up_counter == $past(up_counter) + 8'h01;
    endproperty
    a_count_step: assert property (p_count_step) else $error("counter did not step by one");

    property p_stop_clear;
        @(posedge clk) disable iff (sys_rst)
        !count_enable |=> up_counter == 8'h00;
    endproperty
    a_stop_clear: assert property (p_stop_clear) else $error("stopped counter not zero");

    property p_match_clear;
        @(posedge clk) disable iff (sys_rst)
        match_event |=> up_counter == 8'h00 && irq_status;
    endproperty
    a_match_clear: assert property (p_match_clear) else $error("match did not clear and flag");

    property p_match_irq;
        @(posedge clk) disable iff (sys_rst)
        (count_enable && count_tick && !pwm_mode_select && up_counter == compare_value) |=> irq_status;
    endproperty
    a_match_irq: assert property (p_match_irq) else $error("match flag not set");

    property p_pwm_no_irq;
        @(posedge clk) disable iff (sys_rst)
        $rose(irq_status) |-> !$past(pwm_mode_select);
    endproperty
    a_pwm_no_irq: assert property (p_pwm_no_irq) else $error("interrupt raised in PWM mode");

    property p_compare_write;
        @(posedge clk) disable iff (sys_rst)
        wr_compare |=> compare_value == $past(writedata[7:0]);
    endproperty
    a_compare_write: assert property (p_compare_write) else $error("compare write lost");

    property p_clksel_write;
        @(posedge clk) disable iff (sys_rst)
        wr_clksel |=> clock_select_reg == $past(writedata[2:0]);
    endproperty
    a_clksel_write: assert property (p_clksel_write) else $error("clock select write lost");

    property p_out_low;
        @(posedge clk) disable iff (sys_rst)
        !output_enable |=> !timer_output_pin;
    endproperty
    a_out_low: assert property (p_out_low) else $error("output not low when disabled");

    property p_level_clear;
        @(posedge clk) disable iff (sys_rst)
        (wr_mode && !writedata[`BIT_PWM_MODE] && writedata[3:2] == 2'b01) |=> !out_ff;
    endproperty
    a_level_clear: assert property (p_level_clear) else $error("level reset ignored");

    property p_toggle;
        @(posedge clk) disable iff (sys_rst)
        (match_event && invert_or_polarity && !wr_mode) |=> out_ff != $past(out_ff);
    endproperty
    a_toggle: assert property (p_toggle) else $error("no toggle on match");

    property p_pwm_duty;
        @(posedge clk) disable iff (sys_rst)
        (output_enable && pwm_mode_select && !invert_or_polarity) |=>
            timer_output_pin == ($past(count_enable) && ($past(up_counter) < $past(compare_value)));
    endproperty
    a_pwm_duty: assert property (p_pwm_duty) else $error("PWM level wrong");
endmodule // eight_bit_timer_event_counter
`default_nettype wire

// File: testbench/timer_pins_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------------
// Far side of the timer: drives the event pin and watches the output pin.
// ----------------------------------------------------------------------------
module timer_pins_model (
    // Clock.
    input  wire logic clk,
    // Timer pins.
    output logic      event_input_pin,
    input  wire logic timer_output_pin
);
    // Idle low, so a rising-edge source sees no false edge at start.
    initial event_input_pin = 1'b0;

    // Pulses stay three cycles high and at least three low, well above the sampling rate.
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge clk);
            event_input_pin <= 1'b1;
            repeat (3) @(posedge clk);
            event_input_pin <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask

    // Counts high cycles and level changes of the output, sampled mid-cycle.
    task automatic watch(input int n, output int hi, output int tg);
        logic last;
        hi = 0;
        tg = 0;
        @(negedge clk);
        last = timer_output_pin;
        repeat (n) begin
            @(negedge clk);
            hi += int'(timer_output_pin === 1'b1);
            tg += int'(timer_output_pin !== last);
            last = timer_output_pin;
        end
    endtask
endmodule // timer_pins_model
`default_nettype wire

// File: testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "timer8_cfg.svh"
module tb_top;
    // ------------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------------
    localparam logic [15:0] A_CNT = `IDX_COUNTER_CH0;
    localparam logic [15:0] A_CMP = `IDX_COMPARE_CH0;
    localparam logic [15:0] A_SEL = `IDX_CLKSEL_CH0;
    localparam logic [15:0] A_MOD = `IDX_MODE_CH0;
    localparam logic [15:0] A_STS = `IDX_IRQ_STATUS_CH0;
    localparam logic [15:0] A_MSK = `IDX_IRQ_MASK_CH0;
    logic        clk;
    logic        sys_rst;
    logic [15:0] address;
    logic        read;
    logic        write;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        event_input_pin;
    logic        timer_output_pin;
    logic        match_irq;
    logic [31:0] readdata_ch1;
    logic        waitrequest_ch1;
    logic        timer_output_pin_ch1;
    logic        match_irq_ch1;
    logic [31:0] rd;
    int          n_mismatch = 0;
    int          checks_done = 0;
    int          cycles = 0;
    int          hi;
    int          tg;
    logic [15:0] regs [6] = '{A_CNT, A_CMP, A_SEL, A_MOD, A_STS, A_MSK};
    int          div_code [6] = '{2, 3, 4, 5, 6, 7};
    int          div_len [6] = '{1, 2, 4, 64, 256, 8};

    // Slowest divider is shortened so the whole table runs quickly.
    eight_bit_timer_event_counter #(.CHANNEL(0), .EXP_CODE7(3)) u_eight_bit_timer_event_counter (
        .clk(clk), .sys_rst(sys_rst), .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .event_input_pin(event_input_pin),
        .timer_output_pin(timer_output_pin), .match_irq(match_irq));

    timer_pins_model u_timer_pins_model (
        .clk(clk), .event_input_pin(event_input_pin), .timer_output_pin(timer_output_pin));

    // Channel 1 shares the bus; each channel reads zero outside its own map, so read data are ORed.
    eight_bit_timer_event_counter #(.CHANNEL(1), .EXP_CODE7(3)) u_eight_bit_timer_event_counter_ch1 (
        .clk(clk), .sys_rst(sys_rst), .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata), .readdata(readdata_ch1),
        .waitrequest(waitrequest_ch1), .event_input_pin(event_input_pin),
        .timer_output_pin(timer_output_pin_ch1), .match_irq(match_irq_ch1));

    // ------------------------------------------------------------------------
    // Clock, timeout and tasks
    // ------------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // A hang is counted as a failure rather than left to run forever.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            close_out();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // Request is held until the edge that samples waitrequest low.
    task automatic bus_wr(input logic [15:0] a, input logic [7:0] d, input logic [3:0] be = 4'h1);
        @(posedge clk);
        address <= a;
        writedata <= {24'h000000, d};
        byteenable <= be;
        write <= 1'b1;
        @(posedge clk);
        while ((waitrequest | waitrequest_ch1) !== 1'b0) @(posedge clk);
        write <= 1'b0;
    endtask

    task automatic bus_rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge clk);
        address <= a;
        read <= 1'b1;
        @(posedge clk);
        while ((waitrequest | waitrequest_ch1) !== 1'b0) @(posedge clk);
        d = readdata | readdata_ch1;
        read <= 1'b0;
    endtask

    task automatic settle();
        repeat (2) @(negedge clk);
    endtask

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        address = 16'h0000;
        read = 1'b0;
        write = 1'b0;
        byteenable = 4'h0;
        writedata = 32'h00000000;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        foreach (regs[i]) begin
            bus_rd(regs[i], rd);
            check("reset value", rd, 32'h0);
        end
        check("pin after reset", timer_output_pin, 1'b0);
        $display("Test reset done");

        bus_wr(A_CMP, 8'hA5);
        bus_wr(A_CMP, 8'h5A, 4'h0);
        bus_rd(A_CMP, rd);
        check("compare", rd, 32'hA5);
        bus_wr(A_CMP, 8'hFF);
        bus_rd(A_CMP, rd);
        check("compare top", rd, 32'hFF);
        bus_wr(A_SEL, 8'h05);
        bus_rd(A_SEL, rd);
        check("clock select", rd, 32'h05);
        bus_wr(A_CNT, 8'h33);
        bus_wr(16'h0000, 8'h33);
        bus_rd(A_CNT, rd);
        check("counter read-only", rd, 32'h0);
        bus_rd(16'h0000, rd);
        check("unmapped", rd, 32'h0);
        $display("Test registers done");

        // Interval mode with compare 3 on the raw clock: match every fourth cycle.
        bus_wr(A_SEL, 8'h02);
        bus_wr(A_CMP, 8'h03);
        bus_wr(A_MOD, 8'h0B);
        settle();
        check("level set", timer_output_pin, 1'b1);
        bus_wr(A_MOD, 8'h07);
        settle();
        check("level reset", timer_output_pin, 1'b0);
        bus_wr(A_MOD, 8'h83);
        repeat (10) @(negedge clk);
        check("irq masked", match_irq, 1'b0);
        bus_wr(A_MSK, 8'h01);
        settle();
        check("irq unmasked", match_irq, 1'b1);
        u_timer_pins_model.watch(40, hi, tg);
        check("square wave toggles", tg >= 9 && tg <= 11, 1'b1);
        bus_rd(A_CNT, rd);
        check("counter below compare", rd <= 32'h3, 1'b1);
        bus_rd(A_STS, rd);
        check("match status", rd, 32'h1);
        bus_wr(A_MSK, 8'h00);
        settle();
        check("irq masked again", match_irq, 1'b0);
        bus_wr(A_MOD, 8'h03);
        bus_rd(A_CNT, rd);
        check("stop clears counter", rd, 32'h0);
        bus_wr(A_MOD, 8'h0A);
        settle();
        check("output disabled", timer_output_pin, 1'b0);
        $display("Test interval done");

        // PWM: duty equals compare over one full 256-count period.
        bus_rd(A_STS, rd);
        bus_wr(A_CMP, 8'h40);
        bus_wr(A_MOD, 8'hC1);
        repeat (260) @(posedge clk);
        u_timer_pins_model.watch(256, hi, tg);
        check("pwm duty", hi, 64);
        bus_wr(A_MOD, 8'hC3);
        repeat (260) @(posedge clk);
        u_timer_pins_model.watch(256, hi, tg);
        check("pwm active low", hi, 192);
        bus_wr(A_CMP, 8'h80);
        repeat (260) @(posedge clk);
        u_timer_pins_model.watch(256, hi, tg);
        check("pwm new compare", hi, 128);
        bus_rd(A_STS, rd);
        check("pwm no irq", rd, 32'h0);
        $display("Test pwm done");

        // Event pin as count source, rising then falling edges.
        for (int k = 1; k >= 0; k--) begin
            bus_wr(A_MOD, 8'h00);
            bus_wr(A_CMP, 8'hFF);
            bus_wr(A_SEL, 8'(k));
            bus_wr(A_MOD, 8'h80);
            u_timer_pins_model.pulses(5);
            bus_rd(A_CNT, rd);
            check("event count", rd, 32'h5);
        end
        $display("Test events done");

        // Each divider: about eight ticks in eight periods, allowing phase slack.
        foreach (div_code[i]) begin
            bus_wr(A_MOD, 8'h00);
            bus_wr(A_SEL, 8'(div_code[i]));
            bus_wr(A_MOD, 8'h80);
            repeat (8 * div_len[i]) @(posedge clk);
            bus_rd(A_CNT, rd);
            check("ticks per divider", rd >= 32'h7 && rd <= 32'hB, 1'b1);
        end
        $display("Test dividers done");

        // Channel 1: code 100 divides by sixteen, so eight periods give about eight ticks.
        bus_wr(`IDX_COMPARE_CH1, 8'hFF);
        bus_wr(`IDX_CLKSEL_CH1, 8'h04);
        bus_wr(`IDX_MODE_CH1, 8'h80);
        repeat (128) @(posedge clk);
        bus_rd(`IDX_COUNTER_CH1, rd);
        check("ch1 divide by 16", rd >= 32'h7 && rd <= 32'hB, 1'b1);
        check("ch1 pin and irq idle", {timer_output_pin_ch1, match_irq_ch1}, 2'b00);
        $display("Test channel 1 done");
        close_out();
    end
endmodule // tb_top
`default_nettype wire
